// >>> hdl/rps_defines.vh
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH

// ==================================================
// timing figures
`define RPS_CLK_NS      50
`define RPS_TICK_US     2000
`define RPS_LOCKOUT_MS  10000
`define RPS_WAKE_MS     33000
`define RPS_WINDOW_MS   66
`define RPS_BLINK0_MS   1000
`define RPS_BLINK1_MS   500

// derived counts: cycles per tick, then ticks per interval
`define RPS_TICK_CYC    ((`RPS_TICK_US * 1000) / `RPS_CLK_NS)
`define RPS_LOCKOUT_TK  ((`RPS_LOCKOUT_MS * 1000 + `RPS_TICK_US - 1) / `RPS_TICK_US)
`define RPS_WAKE_TK     ((`RPS_WAKE_MS * 1000) / `RPS_TICK_US)
`define RPS_WINDOW_TK   ((`RPS_WINDOW_MS * 1000) / `RPS_TICK_US)
`define RPS_BLINK0_TK   ((`RPS_BLINK0_MS * 1000) / `RPS_TICK_US)
`define RPS_BLINK1_TK   ((`RPS_BLINK1_MS * 1000) / `RPS_TICK_US)

// ==================================================
// register offsets
`define RPS_OFS_CTRL    8'h00
`define RPS_OFS_CB0     8'h04
`define RPS_OFS_CB1     8'h08
`define RPS_OFS_SLPT    8'h0C
`define RPS_OFS_SLPI    8'h10
`define RPS_OFS_VEN     8'h14
`define RPS_OFS_UVRST   8'h18
`define RPS_OFS_STAT    8'h1C
`define RPS_OFS_VTHR    8'h20
`define RPS_OFS_VDLY    8'h40
`define RPS_OFS_END     8'h60

// ==================================================
// control fields and reset values
`define RPS_CTRL_SLEEP  0
`define RPS_CTRL_WKTMR  1
`define RPS_CTRL_WKMAIN 2
`define RPS_CTRL_WKOVR  3
`define RPS_CTRL_POL    4
`define RPS_CTRL_RETRY  8
`define RPS_CTRL_DIR    16
`define RPS_CTRL_RST    32'h0000_030E
`define RPS_POL_TOGGLE  2'h0
`define RPS_POL_LIMITED 2'h1
`define RPS_POL_UNLIM   2'h2
`define RPS_RESP_OKAY   2'h0
`define RPS_RESP_SLVERR 2'h2

`endif

// >>> hdl/rps_vchan.v
`timescale 1ns/1ps
`include "rps_defines.vh"

// ==================================================
// one voltage threshold and delay channel
module rps_vchan #(
	parameter W = 16
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire          tick,
	input  wire          en,
	input  wire          over,
	input  wire [W-1:0]  level,
	input  wire [W-1:0]  thresh,
	input  wire [31:0]   delay,
	output reg           fault,
	output wire          running
);
	reg  [31:0] cnt;
	wire        beyond;

	// direction of the crossing picks under or over
	assign beyond  = over ? (level > thresh) : (level < thresh);
	assign running = en & beyond & ~fault;

	// delay restarts as soon as the level comes back inside
	always @(posedge aclk) begin
		if (!aresetn || !en || !beyond) begin
			cnt   <= 32'h0000_0000;
			fault <= 1'b0;
		end else if (cnt == delay) begin
			fault <= 1'b1;
		end else if (tick) begin
			cnt <= cnt + 32'h0000_0001;
		end
	end
endmodule

// >>> hdl/rps_supervisor.v
// Functional notes
// - two programmable circuit-break current levels trip the switch, apart from fixed protection
// - uni-directional build sees source-to-load only; bi-directional picks direction per level
// - circuit-break trip blinks the fault indicator with that level's pattern
// - reset policy: main toggle, limited auto-retry or unlimited auto-retry
// - limited retry counts resets, then falls back to main trigger toggle
// - every circuit-break reset waits at least 10 s lockout after trip
// - switch opens when voltage stays beyond threshold for programmed delay
// - voltage thresholds in 0.1 V steps over the full range
// - voltage delays in 2 ms steps with a wide counter
// - four under- and four over-voltage channels, each independent
// - voltage fault opens switch; steady indicator only without higher faults
// - during voltage fault override closes switch only while main is active
// - idle: no timer running, no fixed or break fault, closed current below threshold
// - sleep timer runs while idle, cleared on any idle condition change
// - idle for full sleep time opens switch, darkens indicators, enters low power
// - wakes about every 33 s, restores state and monitors voltages and current
// - wake becomes permanent on idle change or source above under-voltage reset
// - no change within 66 ms returns to low power
// - main or override trigger change also ends sleep
// - timer, main and override wake sources each have their own enable
// - indicator shows highest-priority active fault, falling back when it clears
`timescale 1ns/1ps
`include "rps_defines.vh"

module rps_supervisor #(
	parameter        BIDIR         = 0,
	parameter [31:0] TICK_CYCLES   = `RPS_TICK_CYC,
	parameter [31:0] LOCKOUT_TICKS = `RPS_LOCKOUT_TK,
	parameter [31:0] WAKE_TICKS    = `RPS_WAKE_TK,
	parameter [31:0] WINDOW_TICKS  = `RPS_WINDOW_TK,
	parameter [31:0] BLINK0_TICKS  = `RPS_BLINK0_TK,
	parameter [31:0] BLINK1_TICKS  = `RPS_BLINK1_TK
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	input  wire        main_trig,
	input  wire        ovr_trig,
	input  wire [15:0] load_current,
	input  wire        current_rev,
	input  wire [15:0] source_volt,
	input  wire        oc_fault,
	input  wire        sc_fault,
	input  wire        ot_fault,
	input  wire        ext_blink,
	input  wire        trig_delay_busy,
	input  wire        prot_timer_busy,
	output reg         switch_close,
	output reg         fault_led,
	output wire        leds_off,
	output wire        low_power
);
	localparam ST_AWAKE = 2'h0;
	localparam ST_LP    = 2'h1;
	localparam ST_PEEK  = 2'h2;

	// ==================================================
	// declarations
	reg  [31:0] ctrl;
	reg  [31:0] cb_cfg [0:1];
	reg  [31:0] slp_time;
	reg  [15:0] slp_cur;
	reg  [7:0]  ven;
	reg  [15:0] uv_rst;
	reg  [15:0] vthr [0:7];
	reg  [31:0] vdly [0:7];
	reg         aw_hold;
	reg         w_hold;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg  [31:0] rd_mux;
	reg         main_m;
	reg         main_s;
	reg         main_q;
	reg         ovr_m;
	reg         ovr_s;
	reg         ovr_q;
	reg  [31:0] tick_cnt;
	reg         tick;
	reg         cb_trip;
	reg         cb_lvl;
	reg  [31:0] lock_cnt;
	reg         main_off;
	reg  [7:0]  retry_cnt;
	reg  [31:0] blink_cnt;
	reg         blink;
	reg  [1:0]  state;
	reg  [31:0] slp_cnt;
	reg  [31:0] wk_cnt;
	reg  [8:0]  prev_vec;
	wire [1:0]  cb_hit;
	wire [1:0]  cb_run;
	wire [7:0]  vfault;
	wire [7:0]  vrun;
	wire [8:0]  idle_vec;
	wire        idle;
	wire        vf;
	wire        lp;
	wire        lock_done;
	wire        auto_ok;
	wire        trig_wake;
	wire        uv_up;
	wire        next_switch;
	wire        next_led;
	wire        going_lp;
	wire [31:0] half;
	wire [1:0]  pol;

	// ==================================================
	// write strobe merge
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		integer      b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (st[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
		end
	endfunction

	// half-word merge keeps narrow registers from losing bits silently
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  st;
		begin
			merge16 = old;
			if (st[0])
				merge16[7:0] = nw[7:0];
			if (st[1])
				merge16[15:8] = nw[15:8];
		end
	endfunction

	// ==================================================
	// bus slave: address and data taken in either order
	assign awready = ~aw_hold & ~bvalid;
	assign wready  = ~w_hold & ~bvalid;
	assign arready = ~rvalid;

	// register writes complete when both halves are held
	always @(posedge aclk) begin : wr_proc
		integer k;
		if (!aresetn) begin
			aw_hold  <= 1'b0;
			w_hold   <= 1'b0;
			aw_addr  <= 8'h00;
			w_data   <= 32'h0000_0000;
			w_strb   <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= `RPS_RESP_OKAY;
			ctrl     <= `RPS_CTRL_RST;
			slp_time <= 32'h0000_0000;
			slp_cur  <= 16'h0000;
			ven      <= 8'h00;
			uv_rst   <= 16'h0000;
			cb_cfg[0] <= 32'hFFFF_FFFF;
			cb_cfg[1] <= 32'hFFFF_FFFF;
			for (k = 0; k < 8; k = k + 1) begin
				vthr[k] <= 16'h0000;
				vdly[k] <= 32'h0000_0000;
			end
		end else begin
			if (awvalid && awready) begin
				aw_hold <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (aw_hold && w_hold && !bvalid) begin
				aw_hold <= 1'b0;
				w_hold  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (aw_addr < `RPS_OFS_END) ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
				case (aw_addr[7:2])
				`RPS_OFS_CTRL >> 2:  ctrl      <= merge(ctrl, w_data, w_strb);
				`RPS_OFS_CB0 >> 2:   cb_cfg[0] <= merge(cb_cfg[0], w_data, w_strb);
				`RPS_OFS_CB1 >> 2:   cb_cfg[1] <= merge(cb_cfg[1], w_data, w_strb);
				`RPS_OFS_SLPT >> 2:  slp_time  <= merge(slp_time, w_data, w_strb);
				`RPS_OFS_SLPI >> 2:  slp_cur   <= merge16(slp_cur, w_data[15:0], w_strb[1:0]);
				`RPS_OFS_VEN >> 2:   ven       <= w_strb[0] ? w_data[7:0] : ven;
				`RPS_OFS_UVRST >> 2: uv_rst    <= merge16(uv_rst, w_data[15:0], w_strb[1:0]);
				default: begin
					if (aw_addr[7:5] == 3'h1)
						vthr[aw_addr[4:2]] <= merge16(vthr[aw_addr[4:2]], w_data[15:0], w_strb[1:0]);
					if (aw_addr[7:5] == 3'h2)
						vdly[aw_addr[4:2]] <= merge(vdly[aw_addr[4:2]], w_data, w_strb);
				end
				endcase
			end
		end
	end

	// read mux; unmapped words read as zero
	always @* begin
		rd_mux = 32'h0000_0000;
		case (araddr[7:2])
		`RPS_OFS_CTRL >> 2:  rd_mux = ctrl;
		`RPS_OFS_CB0 >> 2:   rd_mux = cb_cfg[0];
		`RPS_OFS_CB1 >> 2:   rd_mux = cb_cfg[1];
		`RPS_OFS_SLPT >> 2:  rd_mux = slp_time;
		`RPS_OFS_SLPI >> 2:  rd_mux = {16'h0000, slp_cur};
		`RPS_OFS_VEN >> 2:   rd_mux = {24'h00_0000, ven};
		`RPS_OFS_UVRST >> 2: rd_mux = {16'h0000, uv_rst};
		`RPS_OFS_STAT >> 2:  rd_mux = {state, retry_cnt, vfault, 9'h000, lp, idle, cb_lvl, cb_trip, switch_close};
		default: begin
			if (araddr[7:5] == 3'h1)
				rd_mux = {16'h0000, vthr[araddr[4:2]]};
			if (araddr[7:5] == 3'h2)
				rd_mux = vdly[araddr[4:2]];
		end
		endcase
	end

	// read answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `RPS_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= (araddr < `RPS_OFS_END) ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==================================================
	// trigger pins: two flops, third flop only for edges
	always @(posedge aclk) begin
		if (!aresetn) begin
			{main_m, main_s, main_q} <= 3'h0;
			{ovr_m, ovr_s, ovr_q}    <= 3'h0;
		end else begin
			{main_m, main_s, main_q} <= {main_trig, main_m, main_s};
			{ovr_m, ovr_s, ovr_q}    <= {ovr_trig, ovr_m, ovr_s};
		end
	end

	// free-running tick; every delay counts these, not clocks
	always @(posedge aclk) begin
		if (!aresetn || tick_cnt == TICK_CYCLES - 32'h1) begin
			tick_cnt <= 32'h0000_0000;
			tick     <= aresetn;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
			tick     <= 1'b0;
		end
	end

	// ==================================================
	// circuit-break levels, one counter each
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : cb_gen
			reg  [15:0] cnt;
			wire        dir_ok;
			wire        over;
			assign dir_ok = (BIDIR != 0) ? (current_rev == ctrl[`RPS_CTRL_DIR + g]) : ~current_rev;
			assign over   = dir_ok & switch_close & (load_current >= cb_cfg[g][15:0]);
			assign cb_hit[g] = over & (cnt == cb_cfg[g][31:16]);
			assign cb_run[g] = over & ~cb_hit[g];
			always @(posedge aclk) begin
				if (!aresetn || !over || cb_trip)
					cnt <= 16'h0000;
				else if (tick && !cb_hit[g])
					cnt <= cnt + 16'h0001;
			end
		end
	endgenerate

	// ==================================================
	// trip, lockout and reset policy
	assign pol       = ctrl[`RPS_CTRL_POL +: 2];
	assign lock_done = (lock_cnt == LOCKOUT_TICKS);
	assign auto_ok   = (pol == `RPS_POL_UNLIM) ||
	                   (pol == `RPS_POL_LIMITED && retry_cnt != ctrl[`RPS_CTRL_RETRY +: 8]);

	// toggle means main seen inactive, then active after the lockout
	always @(posedge aclk) begin
		if (!aresetn) begin
			cb_trip   <= 1'b0;
			cb_lvl    <= 1'b0;
			lock_cnt  <= 32'h0000_0000;
			main_off  <= 1'b0;
			retry_cnt <= 8'h00;
		end else if (!cb_trip) begin
			if (|cb_hit) begin
				cb_trip  <= 1'b1;
				cb_lvl   <= ~cb_hit[0];
				lock_cnt <= 32'h0000_0000;
				main_off <= 1'b0;
			end else if (main_q && !main_s) begin
				retry_cnt <= 8'h00;
			end
		end else begin
			if (tick && !lock_done)
				lock_cnt <= lock_cnt + 32'h1;
			if (!main_s)
				main_off <= 1'b1;
			if (lock_done) begin
				if (auto_ok) begin
					cb_trip <= 1'b0;
					if (pol == `RPS_POL_LIMITED)
						retry_cnt <= retry_cnt + 8'h01;
				end else if (main_off && main_s) begin
					cb_trip   <= 1'b0;
					retry_cnt <= 8'h00;
				end
			end
		end
	end

	// ==================================================
	// voltage channels: 0..3 under, 4..7 over
	genvar v;
	generate
		for (v = 0; v < 8; v = v + 1) begin : vch_gen
			rps_vchan #(
				.W (16)
			) u_vchan (
				.aclk    (aclk),
				.aresetn (aresetn),
				.tick    (tick),
				.en      (ven[v] & ~lp),
				.over    (v >= 4),
				.level   (source_volt),
				.thresh  (vthr[v]),
				.delay   (vdly[v]),
				.fault   (vfault[v]),
				.running (vrun[v])
			);
		end
	endgenerate

	assign vf = |vfault;

	// ==================================================
	// switch drive and fault indicator
	// the step into low power is decoded early so the first sleeping cycle is already dark
	assign going_lp    = (state == ST_AWAKE && ctrl[`RPS_CTRL_SLEEP] && idle && idle_vec == prev_vec &&
	                      slp_cnt == slp_time) ||
	                     (state == ST_PEEK && !trig_wake && idle && !uv_up && tick &&
	                      wk_cnt == WINDOW_TICKS - 32'h1);
	assign next_switch = ~lp & ~going_lp & main_s & ~cb_trip & ~oc_fault & ~sc_fault & ~ot_fault &
	                     (~vf | ovr_s);
	assign half = cb_lvl ? BLINK1_TICKS : BLINK0_TICKS;

	// blink phase restarts on each trip so the pattern starts lit
	always @(posedge aclk) begin
		if (!aresetn || !cb_trip) begin
			blink_cnt <= 32'h0000_0000;
			blink     <= 1'b1;
		end else if (tick) begin
			if (blink_cnt == half - 32'h1) begin
				blink_cnt <= 32'h0000_0000;
				blink     <= ~blink;
			end else begin
				blink_cnt <= blink_cnt + 32'h1;
			end
		end
	end

	// fixed-fault patterns come from outside; priority picks one
	assign next_led = (lp | going_lp) ? 1'b0 :
	                  (oc_fault | sc_fault) ? ext_blink :
	                  cb_trip ? blink :
	                  ot_fault ? ext_blink : vf;

	always @(posedge aclk) begin
		if (!aresetn) begin
			switch_close <= 1'b0;
			fault_led    <= 1'b0;
		end else begin
			switch_close <= next_switch;
			fault_led    <= next_led;
		end
	end

	// ==================================================
	// idle detection and sleep sequencing
	assign idle_vec  = {trig_delay_busy, prot_timer_busy, |vrun, |cb_run, ot_fault,
	                    oc_fault, sc_fault, cb_trip, switch_close & (load_current >= slp_cur)};
	assign idle      = ~|idle_vec;
	assign lp        = (state == ST_LP);
	assign low_power = lp;
	assign leds_off  = lp;
	assign trig_wake = (ctrl[`RPS_CTRL_WKMAIN] & (main_s ^ main_q)) |
	                   (ctrl[`RPS_CTRL_WKOVR] & (ovr_s ^ ovr_q));
	assign uv_up     = (|ven[3:0]) & (source_volt > uv_rst);

	// idle is all-zero on entry to sleep, so any set bit in a peek is a change
	always @(posedge aclk) begin
		if (!aresetn) begin
			state    <= ST_AWAKE;
			slp_cnt  <= 32'h0000_0000;
			wk_cnt   <= 32'h0000_0000;
			prev_vec <= 9'h000;
		end else begin
			prev_vec <= idle_vec;
			case (state)
			ST_AWAKE: begin
				wk_cnt <= 32'h0000_0000;
				if (!ctrl[`RPS_CTRL_SLEEP] || !idle || idle_vec != prev_vec)
					slp_cnt <= 32'h0000_0000;
				else if (slp_cnt == slp_time)
					state <= ST_LP;
				else if (tick)
					slp_cnt <= slp_cnt + 32'h1;
			end
			ST_LP: begin
				slp_cnt <= 32'h0000_0000;
				if (trig_wake) begin
					state <= ST_AWAKE;
				end else if (ctrl[`RPS_CTRL_WKTMR] && tick) begin
					if (wk_cnt == WAKE_TICKS - 32'h1) begin
						state  <= ST_PEEK;
						wk_cnt <= 32'h0000_0000;
					end else begin
						wk_cnt <= wk_cnt + 32'h1;
					end
				end
			end
			ST_PEEK: begin
				if (trig_wake || !idle || uv_up) begin
					state <= ST_AWAKE;
				end else if (tick) begin
					if (wk_cnt == WINDOW_TICKS - 32'h1) begin
						state  <= ST_LP;
						wk_cnt <= 32'h0000_0000;
					end else begin
						wk_cnt <= wk_cnt + 32'h1;
					end
				end
			end
			default: state <= ST_AWAKE;
			endcase
		end
	end
endmodule

// >>> test/rps_sense_model.sv
`timescale 1ns/1ps
// ==================================================
// trigger pins, sensing and switch array around the supervisor
module rps_sense_model (
	input  wire        switch_close,
	input  wire        main_cmd,
	input  wire        ovr_cmd,
	input  wire [15:0] demand,
	input  wire [15:0] volt_cmd,
	output wire        main_trig,
	output wire        ovr_trig,
	output wire [15:0] load_current,
	output wire        current_rev,
	output wire [15:0] source_volt
);
	// pins change off the clock, as a real switch would
	assign #7 main_trig = main_cmd;
	assign #11 ovr_trig = ovr_cmd;
	// an open array passes no current, so current only shows when closed
	assign load_current = switch_close ? demand : 16'h0000;
	assign current_rev  = 1'b0;
	// volts in tenths, straight from the bench
	assign source_volt  = volt_cmd;
endmodule

// >>> test/rps_sup_properties.sv
`timescale 1ns/1ps
// ==================================================
// port relations of the supervisor
module rps_sup_properties (
	input wire        aclk,
	input wire        aresetn,
	input wire        awvalid,
	input wire        awready,
	input wire        wvalid,
	input wire        wready,
	input wire [1:0]  bresp,
	input wire        bvalid,
	input wire        bready,
	input wire [7:0]  araddr,
	input wire        arvalid,
	input wire        arready,
	input wire [31:0] rdata,
	input wire [1:0]  rresp,
	input wire        rvalid,
	input wire        rready,
	input wire        main_trig,
	input wire        switch_close,
	input wire        fault_led,
	input wire        leds_off,
	input wire        low_power
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// steps of a transfer
	sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
	sequence rd_taken; arvalid && arready; endsequence
	// sync plus update needs a few edges, so look after five low samples
	sequence main_quiet; !main_trig [*5]; endsequence
	write_answer_a: assert property (wr_taken |-> ##[1:2] bvalid)
		else $error("write got no response");
	bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (rd_taken |=> rvalid)
		else $error("read got no data");
	rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped early");
	arready_gate_a: assert property (arready == !rvalid)
		else $error("read address ready wrong");
	unmapped_read_a: assert property (rd_taken and araddr >= 8'h60 |=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read not refused");
	sleep_dark_a: assert property (low_power |-> !switch_close && !fault_led)
		else $error("switch or led active in low power");
	sleep_leds_a: assert property (low_power |-> leds_off)
		else $error("leds on in low power");
	main_gate_a: assert property (main_quiet |-> !switch_close)
		else $error("switch closed without main trigger");
endmodule

bind rps_supervisor rps_sup_properties i_rps_sup_properties (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .main_trig(main_trig), .switch_close(switch_close), .fault_led(fault_led),
	.leds_off(leds_off), .low_power(low_power)
);

// >>> test/tb.sv
`timescale 1ns/1ps
`include "rps_defines.vh"
// ==================================================
// bench top
module tb;
	reg         aclk = 1'b0;
	reg         aresetn = 1'b0;
	reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
	reg  [31:0] wdata = 32'h0000_0000, rd;
	reg  [3:0]  wstrb = 4'hF;
	reg         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, last;
	reg         main_cmd = 0, ovr_cmd = 0, oc = 0, sc = 0, ot = 0, blink = 0, tbusy = 0, pbusy = 0;
	reg  [15:0] demand = 16'h0000, volt = 16'h0082;
	reg  [1:0]  rsp;
	wire        awready, wready, bvalid, arready, rvalid, main_trig, ovr_trig, current_rev;
	wire        switch_close, fault_led, leds_off, low_power;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] load_current, source_volt;
	integer     num_errors = 0, n_checks = 0, i, n;

	always #25 aclk = ~aclk;

	// short counts keep the run brief; expectations follow them
	rps_supervisor #(.TICK_CYCLES(32'd4), .LOCKOUT_TICKS(32'd5), .WAKE_TICKS(32'd10), .WINDOW_TICKS(32'd3),
		.BLINK0_TICKS(32'd2), .BLINK1_TICKS(32'd2)) i_rps_supervisor (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .main_trig(main_trig), .ovr_trig(ovr_trig),
		.load_current(load_current), .current_rev(current_rev), .source_volt(source_volt),
		.oc_fault(oc), .sc_fault(sc), .ot_fault(ot), .ext_blink(blink), .trig_delay_busy(tbusy),
		.prot_timer_busy(pbusy), .switch_close(switch_close), .fault_led(fault_led),
		.leds_off(leds_off), .low_power(low_power));

	rps_sense_model i_rps_sense_model (.switch_close(switch_close), .main_cmd(main_cmd), .ovr_cmd(ovr_cmd),
		.demand(demand), .volt_cmd(volt), .main_trig(main_trig), .ovr_trig(ovr_trig),
		.load_current(load_current), .current_rev(current_rev), .source_volt(source_volt));

	task complete_run;
		begin
			$display("checks %0d errors %0d", n_checks, num_errors);
			if (num_errors == 0 && n_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] %0s expected %h seen %h", name, exp, seen);
			end
		end
	endtask

	task cyc(input integer c);
		repeat (c) @(posedge aclk);
	endtask

	// both write halves offered at once, each dropped when taken
	task wr(input [7:0] a, input [31:0] d);
		reg     done;
		begin
			done = 0;
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!done) begin
				@(posedge aclk);
				if (awvalid && awready === 1'b1)
					awvalid <= 1'b0;
				if (wvalid && wready === 1'b1)
					wvalid <= 1'b0;
				if (bvalid === 1'b1) begin
					rsp = bresp;
					bready <= 1'b0;
					done = 1;
				end
			end
			@(posedge aclk);
		end
	endtask

	task rdr(input [7:0] a);
		reg     done;
		begin
			done = 0;
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while (!done) begin
				@(posedge aclk);
				if (arvalid && arready === 1'b1)
					arvalid <= 1'b0;
				if (rvalid === 1'b1) begin
					rd = rdata;
					rsp = rresp;
					rready <= 1'b0;
					done = 1;
				end
			end
			@(posedge aclk);
		end
	endtask

	// count fault_led edges, or low_power falls, over a span, read before the edge lands
	task edges(input integer c, input sel);
		begin
			n = 0;
			last = sel ? fault_led : low_power;
			for (i = 0; i < c; i = i + 1) begin
				@(posedge aclk);
				if (sel ? (fault_led !== last) : (last && !low_power))
					n = n + 1;
				last = sel ? fault_led : low_power;
			end
		end
	endtask

	// ==================================================
	// scenarios
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdr(`RPS_OFS_CTRL);
		check("ctrl", rd, `RPS_CTRL_RST);
		rdr(`RPS_OFS_CB0);
		check("cb0", rd, 32'hFFFF_FFFF);
		rdr(8'h60);
		check("bad_rd", {rsp, rd[29:0]}, {`RPS_RESP_SLVERR, 30'h0});
		wr(8'h60, 32'h0000_0001);
		check("bad_wr", rsp, `RPS_RESP_SLVERR);
		wr(`RPS_OFS_STAT, 32'hFFFF_FFFF);
		rdr(`RPS_OFS_STAT);
		check("stat_ro", rd & 32'h0000_0007, 32'h0000_0000);
		// sleep with timer and override wake only
		wr(`RPS_OFS_VEN, 32'h0000_0000);
		wr(`RPS_OFS_SLPT, 32'h0000_0003);
		wr(`RPS_OFS_SLPI, 32'h0000_0032);
		wr(`RPS_OFS_CTRL, 32'h0000_030B);
		cyc(30);
		check("sleep", low_power, 1'b1);
		edges(120, 1'b0);
		check("peeks", n >= 2, 1'b1);
		ovr_cmd <= 1'b1;
		cyc(6);
		check("wake", low_power, 1'b0);
		wr(`RPS_OFS_CTRL, `RPS_CTRL_RST);
		ovr_cmd <= 1'b0;
		main_cmd <= 1'b1;
		cyc(8);
		check("close", switch_close, 1'b1);
		// under-voltage on the first channel
		wr(`RPS_OFS_VTHR, 32'h0000_0078);
		wr(`RPS_OFS_VDLY, 32'h0000_0002);
		wr(`RPS_OFS_VEN, 32'h0000_0001);
		volt <= 16'h0076;
		cyc(2);
		check("vdelay", switch_close, 1'b1);
		cyc(20);
		check("vtrip", switch_close, 1'b0);
		check("vled", fault_led, 1'b1);
		rdr(`RPS_OFS_STAT);
		check("vchan", rd[21:14], 8'h01);
		ot <= 1'b1;
		cyc(3);
		check("prio", fault_led, 1'b0);
		ot <= 1'b0;
		oc <= 1'b1;
		cyc(3);
		check("prio_oc", fault_led, 1'b0);
		blink <= 1'b1;
		cyc(2);
		check("oc_blink", fault_led, 1'b1);
		oc <= 1'b0;
		blink <= 1'b0;
		ovr_cmd <= 1'b1;
		cyc(6);
		check("ovr", switch_close, 1'b1);
		main_cmd <= 1'b0;
		cyc(6);
		check("ovr_main", switch_close, 1'b0);
		ovr_cmd <= 1'b0;
		volt <= 16'h0082;
		main_cmd <= 1'b1;
		cyc(8);
		check("vclear", switch_close, 1'b1);
		// circuit break on the first level; main stays on, so only a toggle resets
		wr(`RPS_OFS_CB0, 32'h0000_0064);
		demand <= 16'h00C8;
		cyc(4);
		check("cbtrip", switch_close, 1'b0);
		demand <= 16'h0000;
		rdr(`RPS_OFS_STAT);
		check("cbstat", rd[2:1], 2'b01);
		edges(40, 1'b1);
		check("blink", n >= 3 && n <= 6, 1'b1);
		check("notoggle", switch_close, 1'b0);
		main_cmd <= 1'b0;
		cyc(6);
		main_cmd <= 1'b1;
		cyc(8);
		check("cbreset", switch_close, 1'b1);
		// a toggle inside the lockout still waits for its end
		demand <= 16'h00C8;
		cyc(3);
		demand <= 16'h0000;
		main_cmd <= 1'b0;
		cyc(4);
		main_cmd <= 1'b1;
		cyc(4);
		check("lockout", switch_close, 1'b0);
		cyc(20);
		check("relock", switch_close, 1'b1);
		// limited retry of one, set through byte strobes
		wstrb <= 4'h3;
		wr(`RPS_OFS_CTRL, 32'hFFFF_011E);
		wstrb <= 4'hF;
		rdr(`RPS_OFS_CTRL);
		check("strobe", rd, 32'h0000_011E);
		for (i = 0; i < 2; i = i + 1) begin
			demand <= 16'h00C8;
			cyc(3);
			demand <= 16'h0000;
			cyc(25);
			check("retry", switch_close, i == 0);
		end
		complete_run;
	end

	// the whole sequence needs well under this span
	initial begin
		repeat (4000) @(posedge aclk);
		num_errors = num_errors + 1;
		complete_run;
	end
endmodule
